//--- io_port_watchdog_tb.sv
// holds the self-checking bench for the io port watchdog top module.
// assumes wdog_top with one-cycle host strobes and a shortened ms divider.
`default_nettype none
module io_port_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // signals and expected timing
  // ****************************************
  localparam int ms_div      = 10;     // cycles per simulated ms
  localparam int cycle_limit = 90000;  // run needs about 67000
  logic        clk_sys_i;
  logic        reset_i;
  logic [15:0] io_addr_i;
  logic [7:0]  io_wdata_i;
  logic        io_wr_i;
  logic        io_rd_i;
  logic [7:0]  io_rdata_o;
  logic        io_rvalid_o;
  logic        led_red_o;
  logic        timer_alarm_o;
  int          miscompares = 0;
  int          n_compared  = 0;
  int          n_cycles    = 0;
  logic [7:0]  got;
  logic [7:0]  cfg;
  int          std_ms [8] = '{94, 210, 340, 460, 590, 710, 840, 960};
  int          ext_ms [8] = '{2000, 4000, 6000, 8000, 16000, 32000, 48000,
                              64000};

  wdog_top #(.MS_DIV(17'(ms_div))) u_dut (
    .clk_sys_i    (clk_sys_i),
    .reset_i      (reset_i),
    .io_addr_i    (io_addr_i),
    .io_wdata_i   (io_wdata_i),
    .io_wr_i      (io_wr_i),
    .io_rd_i      (io_rd_i),
    .io_rdata_o   (io_rdata_o),
    .io_rvalid_o  (io_rvalid_o),
    .led_red_o    (led_red_o),
    .timer_alarm_o(timer_alarm_o)
  );

  // ****************************************
  // clock, hang guard and helpers
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // cuts a hang short and reports it as a mismatch
  always @(posedge clk_sys_i) begin
    n_cycles++;
    if (n_cycles == cycle_limit) begin
      miscompares++;
      print_verdict();
    end
  end

  // expected timeout in cycles for a range and scaler code
  function automatic int tmo(input logic rng, input logic [2:0] c);
    return (rng ? ext_ms[c] : std_ms[c]) * ms_div;
  endfunction

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // one write strobe, released just after the edge that takes it
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    io_wr_i = 1'b0;
  endtask

  // one read strobe; the answer stands in the cycle after the edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    io_rd_i = 1'b0;
    check("rvalid", {7'h00, io_rvalid_o}, 8'h01);
    d = io_rdata_o;
  endtask

  // lets a configuration run out, then clears the alarm flag
  task automatic expire(input logic [7:0] c);
    wr(16'h0062, c);
    idle(tmo(c[1], c[5:3]) - 10);
    check("alarm early", {7'h00, timer_alarm_o}, 8'h00);
    idle(20);
    check("alarm", {7'h00, timer_alarm_o}, 8'h01);
    rd(16'h0062, got);
    check("flag", got, {1'b1, c[6:0]});
    wr(16'h0062, 8'h00);
    check("alarm kept", {7'h00, timer_alarm_o}, 8'h01);
    wr(16'h0062, 8'h80);
    check("alarm clear", {7'h00, timer_alarm_o}, 8'h00);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(24679));
    reset_i = 1'b1;
    io_addr_i = 16'h0000;
    io_wdata_i = 8'h00;
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    repeat (5) @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
    rd(16'h0062, got);
    check("ctrl reset", got, 8'h00);
    // random bytes with the watchdog off
    repeat (20) begin
      cfg = 8'($urandom()) & 8'hfe;
      wr(16'h0062, cfg);
      check("led", {7'h00, led_red_o}, {7'h00, cfg[6]});
      rd(16'h0062, got);
      check("ctrl", got, {1'b0, cfg[6:0]});
    end
    rd(16'h0070, got);
    check("unmapped", got, 8'h00);
    // kicks closer than the timeout hold the alarm off
    wr(16'h0062, 8'h01);
    repeat (4) begin
      idle(800);
      check("no alarm", {7'h00, timer_alarm_o}, 8'h00);
      rd(16'h0066, got);
      check("kick data", got, 8'h00);
    end
    wr(16'h0062, 8'h00);
    idle(1200);
    check("disabled", {7'h00, timer_alarm_o}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      expire({2'b00, 3'(i), 3'b001} | (8'($urandom()) & 8'h44));
    end
    expire(8'h03);
    // reset in mid-run puts every field and output back to default
    wr(16'h0062, 8'h7b);
    reset_i = 1'b1;
    idle(2);
    reset_i = 1'b0;
    check("led reset", {7'h00, led_red_o}, 8'h00);
    check("alarm reset", {7'h00, timer_alarm_o}, 8'h00);
    rd(16'h0062, got);
    check("ctrl rerun", got, 8'h00);
    print_verdict();
  end
endmodule // io_port_watchdog_tb
`default_nettype wire

//--- wdog_ms_tick.sv
// holds the millisecond enable divider for the watchdog.
// assumes a single system clock with synchronous active-high reset.
`default_nettype none
module wdog_ms_tick #(
  parameter logic [16:0] DIV = wdog_pkg::MS_DIV
) (
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic clear_i,
  output var  logic tick_o
);
  logic [16:0] cnt_ff;

  // ****************************************
  // divider
  // ****************************************
  // counts cycles, pulses once per period; clear restarts the phase
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || clear_i) begin
      cnt_ff <= 17'h0_0000;
      tick_o <= 1'b0;
    end else if (cnt_ff == DIV - 17'h0_0001) begin
      cnt_ff <= 17'h0_0000;
      tick_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 17'h0_0001;
      tick_o <= 1'b0;
    end
  end
endmodule : wdog_ms_tick
`default_nettype wire

//--- wdog_pkg.sv
// holds constants for the io port watchdog: port addresses, field layout,
// reset values and timeout tables at the 100 MHz system clock.
// assumes a byte-wide host i/o port access with one-cycle strobes.
//
// Overview of operation
// (R1) reading the kick port restarts the countdown
// (R2) control byte read/write at port 062h
// (R3) bit 0 enables the watchdog
// (R4) bit 1 range, bits 5:3 pick timeout
// (R5) timeout code resets to 000
// (R6) bit 6 drives the red led
// (R7) bit 7 alarm flag, host writes 1 to clear
// (R8) timeout without kick sets alarm and output
`default_nettype none
package wdog_pkg;
  // ****************************************
  // port map
  // ****************************************
  localparam logic [15:0] ADDR_CONTROL = 16'h0062;
  localparam logic [15:0] ADDR_KICK    = 16'h0066;

  // ****************************************
  // control fields
  // ****************************************
  localparam int BIT_ENABLE  = 0;
  localparam int BIT_RANGE   = 1;
  localparam int BIT_SEL_LO  = 3;
  localparam int BIT_LED     = 6;
  localparam int BIT_ALARM   = 7;
  localparam logic [2:0] RST_SEL = 3'h0;
  localparam logic       RST_BIT = 1'b0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ    = 100_000_000;
  localparam int MS_CYCLES = CLK_HZ / 1000;   // ticks of the ms prescaler
  localparam logic [16:0] MS_DIV = 17'(MS_CYCLES);
  localparam int TICK_W    = 17;             // ms counter width, up to 64000

  // timeout per code, in milliseconds
  localparam logic [16:0] STD_MS [8] = '{
    17'd94, 17'd210, 17'd340, 17'd460,
    17'd590, 17'd710, 17'd840, 17'd960};
  localparam logic [16:0] EXT_MS [8] = '{
    17'd2000, 17'd4000, 17'd6000, 17'd8000,
    17'd16000, 17'd32000, 17'd48000, 17'd64000};
endpackage : wdog_pkg
`default_nettype wire

//--- wdog_top.sv
// holds the io port watchdog: control byte, kick port, countdown, alarm.
// assumes the host presents addr, write data and one-cycle rd/wr strobes
// on the system clock; reads answer on the following cycle.
`default_nettype none
module wdog_top #(
  parameter logic [16:0] MS_DIV = wdog_pkg::MS_DIV
) (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  output var  logic [7:0]  io_rdata_o,
  output var  logic        io_rvalid_o,
  output var  logic        led_red_o,
  output var  logic        timer_alarm_o
);
  // ****************************************
  // decode
  // ****************************************
  logic sel_ctl;
  logic sel_kick;
  assign sel_ctl  = (io_addr_i == wdog_pkg::ADDR_CONTROL); // R2
  assign sel_kick = (io_addr_i == wdog_pkg::ADDR_KICK);

  logic        watchdog_on_bit_ff;
  logic        range_ff;
  logic        rsvd_ff;
  logic [2:0]  sel_ff;
  logic        alarm_ff;
  logic [16:0] ms_left_ff;
  logic        ms_tick;
  logic        kick;
  logic        expire;
  logic        wr_ctl;
  logic [16:0] nxt_load;
  logic [16:0] wr_load;
  logic [2:0]  wr_sel;

  assign kick   = io_rd_i && sel_kick; // R1
  assign wr_ctl = io_wr_i && sel_ctl;

  // ****************************************
  // configuration byte
  // ****************************************
  // enable, range, reserved bit, scaler and led all plain storage
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      watchdog_on_bit_ff <= wdog_pkg::RST_BIT;
      range_ff           <= wdog_pkg::RST_BIT;
      rsvd_ff            <= wdog_pkg::RST_BIT;
      sel_ff             <= wdog_pkg::RST_SEL; // R5
      led_red_o          <= wdog_pkg::RST_BIT;
    end else if (wr_ctl) begin
      watchdog_on_bit_ff <= io_wdata_i[wdog_pkg::BIT_ENABLE]; // R3
      range_ff  <= io_wdata_i[wdog_pkg::BIT_RANGE]; // R4
      rsvd_ff   <= io_wdata_i[2];
      sel_ff    <= io_wdata_i[wdog_pkg::BIT_SEL_LO +: 3]; // R4
      led_red_o <= io_wdata_i[wdog_pkg::BIT_LED]; // R6
    end
  end

  // ****************************************
  // countdown
  // ****************************************
  // reload value from the range and code, in milliseconds
  always_comb begin
    if (range_ff) begin
      nxt_load = wdog_pkg::EXT_MS[sel_ff]; // R4
    end else begin
      nxt_load = wdog_pkg::STD_MS[sel_ff]; // R4
    end
  end

  // reload value taken from the byte being written, so a write that
  // enables the watchdog counts its new code and not the stored one
  assign wr_sel = io_wdata_i[wdog_pkg::BIT_SEL_LO +: 3];
  always_comb begin
    if (io_wdata_i[wdog_pkg::BIT_RANGE]) begin
      wr_load = wdog_pkg::EXT_MS[wr_sel]; // R4
    end else begin
      wr_load = wdog_pkg::STD_MS[wr_sel]; // R4
    end
  end

  // millisecond enable, restarted on kick, config write or while off so no partial tick
  wdog_ms_tick #(
    .DIV (MS_DIV)
  ) u_tick (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .clear_i   (kick || wr_ctl || !watchdog_on_bit_ff),
    .tick_o    (ms_tick)
  );

  assign expire = watchdog_on_bit_ff && ms_tick &&
                  (ms_left_ff == 17'h0_0001);

  // reload on kick, config write or while off; count down per ms
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ms_left_ff <= wdog_pkg::STD_MS[wdog_pkg::RST_SEL];
    end else if (wr_ctl) begin
      ms_left_ff <= wr_load; // R4
    end else if (kick || !watchdog_on_bit_ff) begin
      ms_left_ff <= nxt_load; // R1
    end else if (expire) begin
      ms_left_ff <= nxt_load; // R8
    end else if (ms_tick) begin
      ms_left_ff <= ms_left_ff - 17'h0_0001;
    end
  end

  // ****************************************
  // alarm flag
  // ****************************************
  // sticky; a firing in the clearing cycle wins over the clear
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      alarm_ff <= 1'b0;
    end else if (expire) begin
      alarm_ff <= 1'b1; // R8
    end else if (wr_ctl && io_wdata_i[wdog_pkg::BIT_ALARM]) begin
      alarm_ff <= 1'b0; // R7
    end
  end

  // output mirrors the flag from its own flop
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      timer_alarm_o <= 1'b0;
    end else if (expire) begin
      timer_alarm_o <= 1'b1; // R8
    end else if (wr_ctl && io_wdata_i[wdog_pkg::BIT_ALARM]) begin
      timer_alarm_o <= 1'b0; // R7
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // control reads back its byte, kick reads zero, others zero
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      io_rdata_o  <= 8'h00;
      io_rvalid_o <= 1'b0;
    end else begin
      io_rvalid_o <= io_rd_i;
      if (io_rd_i && sel_ctl) begin
        io_rdata_o <= {alarm_ff, led_red_o, sel_ff, rsvd_ff, range_ff,
                       watchdog_on_bit_ff}; // R2
      end else begin
        io_rdata_o <= 8'h00;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_kick_reload: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    kick |=> ms_left_ff == $past(nxt_load)) // R1
    else $error("kick did not reload countdown");

  chk_ctl_readback: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    io_rd_i && sel_ctl |=> io_rdata_o == $past({alarm_ff, led_red_o, sel_ff,
      rsvd_ff, range_ff, watchdog_on_bit_ff})) // R2
    else $error("control readback mismatch");

  chk_rvalid_pulse: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    io_rd_i |=> io_rvalid_o) // R2
    else $error("read not answered");

  chk_kick_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    io_rd_i && sel_kick |=> io_rdata_o == 8'h00) // R1
    else $error("kick read not zero");

  chk_off_no_alarm: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !watchdog_on_bit_ff && !alarm_ff |=> !alarm_ff) // R3
    else $error("alarm raised while disabled");

  chk_load_table: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    range_ff && sel_ff == 3'h7 |-> nxt_load == 17'd64000) // R4
    else $error("extended table wrong");

  chk_std_default: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_ctl && !io_wdata_i[1] && io_wdata_i[5:3] == 3'h0
      |=> ms_left_ff == 17'd94) // R5
    else $error("standard default timeout wrong");

  chk_ext_default: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_ctl && io_wdata_i[1] && io_wdata_i[5:3] == 3'h0
      |=> ms_left_ff == 17'd2000) // R5
    else $error("extended default timeout wrong");

  chk_reset_sel: assert property (@(posedge clk_sys_i)
    $past(reset_i) |-> sel_ff == 3'h0 && !alarm_ff) // R5
    else $error("scaler not default after reset");

  chk_led_write: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_ctl |=> led_red_o == $past(io_wdata_i[6])) // R6
    else $error("led does not follow write");

  chk_alarm_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_ctl && io_wdata_i[7] && !expire |=> !alarm_ff && !timer_alarm_o) // R7
    else $error("alarm not cleared");

  chk_alarm_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    alarm_ff && !(wr_ctl && io_wdata_i[7]) |=> alarm_ff) // R7
    else $error("alarm dropped without clear");

  chk_expire_set: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    expire |=> alarm_ff && timer_alarm_o) // R8
    else $error("expiry did not set alarm");

  chk_alarm_mirror: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    timer_alarm_o == alarm_ff) // R8
    else $error("alarm output differs from flag");

  chk_count_step: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ms_tick && watchdog_on_bit_ff && !kick && !wr_ctl && !expire
      |=> ms_left_ff == $past(ms_left_ff) - 17'h0_0001) // R8
    else $error("countdown did not step");
endmodule : wdog_top
`default_nettype wire
